// ===== shared/sphb_pkg.sv
package sphb_pkg;

  // ----------------------------------------
  // Status register bit positions
  // ----------------------------------------
  localparam int STS_OUT_FULL_BIT = 0;
  localparam int STS_IN_FULL_BIT  = 1;
  localparam int STS_F0_BIT       = 2;
  localparam int STS_CD_BIT       = 3;
  localparam int STS_USER_LO      = 4;
  localparam int STS_USER_HI      = 7;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] BUF_RESET  = 8'h00;
  localparam logic [3:0] USER_RESET = 4'h0;
  localparam logic [9:0] PC_RESET   = 10'h000;
  localparam int         CYCLE_NS   = 2500;
  localparam int         CLK_NS     = 20;
  localparam int         CYCLE_CLKS = CYCLE_NS / CLK_NS;
  localparam logic [7:0] CYCLE_LAST = 8'(CYCLE_CLKS - 1);

  // ----------------------------------------
  // Host strobe tracking states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPHB_IDLE  = 2'b00,
    SPHB_WRITE = 2'b01,
    SPHB_READ  = 2'b11
  } sphb_state_t;

endpackage

// ===== rtl/sphb_cycle_strobe.sv
`timescale 1ns/1ns
module sphb_cycle_strobe (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  output logic      cycle_strobe_o
);

  logic [7:0] count;

  // ----------------------------------------
  // Instruction cycle divider
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      count          <= 8'h00;
      cycle_strobe_o <= 1'b0;
    end else begin
      cycle_strobe_o <= (count == sphb_pkg::CYCLE_LAST);
      if (count == sphb_pkg::CYCLE_LAST) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

  a_strobe_spacing: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    $rose(cycle_strobe_o) |=> !cycle_strobe_o [*8])
    else $error("cycle strobe repeated too soon");

endmodule

// ===== rtl/sphb_host_port.sv
`timescale 1ns/1ns
// Behaviour
// - A selected write strobe loads the bus byte into the input buffer.
// - A selected read strobe drives the output buffer or the status.
// - Unselected strobes are ignored and the bus is left undriven.
// - The select line marks each transfer as data or command.
// - There is one 8-bit status register and one buffer per direction.
// - The local input-buffer load clears the input full flag.
// - The local output-buffer store sets the output full flag.
// - Reset clears every status flip-flop and the program counter.
// - A cycle strobe is given once in every instruction cycle.
// - Host-driven flags change only after the strobe's trailing edge.
// - The user status load copies acc bits 4-7 and keeps bits 0-3.
module sphb_host_port (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       read_n_i,
  input  wire logic       write_n_i,
  input  wire logic       data_command_select_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_o,
  input  wire logic [7:0] acc_i,
  input  wire logic       load_input_buffer_to_acc_i,
  input  wire logic       store_acc_to_output_buffer_i,
  input  wire logic       load_user_status_bits_i,
  input  wire logic       user_flag0_i,
  output logic      [7:0] input_buffer_o,
  output logic            input_full_flag_o,
  output logic            output_full_flag_o,
  output logic            command_data_flag_o,
  output logic      [7:0] status_o,
  output logic      [9:0] program_counter_o,
  output logic            cycle_strobe_o
);

  sphb_pkg::sphb_state_t state;
  sphb_pkg::sphb_state_t next_state;
  logic       sel_write;
  logic       sel_read;
  logic       write_done;
  logic       data_read_done;
  logic       held_select;
  logic [7:0] output_buffer;
  logic [3:0] user_bits;

  // ----------------------------------------
  // Strobe qualification
  // ----------------------------------------
  assign sel_write = !chip_select_n_i && !write_n_i;
  assign sel_read  = !chip_select_n_i && !read_n_i;

  always_comb begin
    next_state = state;
    unique case (state)
      sphb_pkg::SPHB_IDLE: begin
        if (sel_write) begin
          next_state = sphb_pkg::SPHB_WRITE;
        end else if (sel_read) begin
          next_state = sphb_pkg::SPHB_READ;
        end
      end
      sphb_pkg::SPHB_WRITE: begin
        if (write_n_i) begin
          next_state = sphb_pkg::SPHB_IDLE;
        end
      end
      sphb_pkg::SPHB_READ: begin
        if (read_n_i) begin
          next_state = sphb_pkg::SPHB_IDLE;
        end
      end
      default: next_state = sphb_pkg::SPHB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= sphb_pkg::SPHB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Trailing edge of a selected strobe
  assign write_done     = (state == sphb_pkg::SPHB_WRITE)
                          && write_n_i;
  assign data_read_done = (state == sphb_pkg::SPHB_READ) && read_n_i
                          && !held_select;

  // ----------------------------------------
  // Input buffer and select capture
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      input_buffer_o <= sphb_pkg::BUF_RESET;
      held_select    <= 1'b0;
    end else if (state == sphb_pkg::SPHB_IDLE && (sel_write || sel_read)) begin
      held_select <= data_command_select_i;
    end else if (state == sphb_pkg::SPHB_WRITE && !write_n_i) begin
      input_buffer_o <= host_data_i;
      held_select    <= data_command_select_i;
    end
  end

  // ----------------------------------------
  // Flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      input_full_flag_o   <= 1'b0;
      command_data_flag_o <= 1'b0;
    end else if (write_done) begin
      input_full_flag_o   <= 1'b1;
      command_data_flag_o <= held_select;
    end else if (load_input_buffer_to_acc_i) begin
      input_full_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_full_flag_o <= 1'b0;
      output_buffer      <= sphb_pkg::BUF_RESET;
    end else if (store_acc_to_output_buffer_i) begin
      output_full_flag_o <= 1'b1;
      output_buffer      <= acc_i;
    end else if (data_read_done) begin
      output_full_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      user_bits <= sphb_pkg::USER_RESET;
    end else if (load_user_status_bits_i) begin
      user_bits <= acc_i[sphb_pkg::STS_USER_HI:
                         sphb_pkg::STS_USER_LO];
    end
  end

  // ----------------------------------------
  // Status word and read data
  // ----------------------------------------
  always_comb begin
    status_o = 8'h00;
    status_o[sphb_pkg::STS_OUT_FULL_BIT] = output_full_flag_o;
    status_o[sphb_pkg::STS_IN_FULL_BIT]  = input_full_flag_o;
    status_o[sphb_pkg::STS_F0_BIT]       = user_flag0_i;
    status_o[sphb_pkg::STS_CD_BIT]       = command_data_flag_o;
    status_o[sphb_pkg::STS_USER_HI:
             sphb_pkg::STS_USER_LO]      = user_bits;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      host_data_o    <= sphb_pkg::BUF_RESET;
      host_data_oe_o <= 1'b0;
    end else begin
      host_data_oe_o <= sel_read;
      host_data_o    <= data_command_select_i ? status_o
                                              : output_buffer;
    end
  end

  // ----------------------------------------
  // Program counter reset
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      program_counter_o <= sphb_pkg::PC_RESET;
    end else if (cycle_strobe_o) begin
      program_counter_o <= program_counter_o + 10'h001;
    end
  end

  sphb_cycle_strobe sphb_cycle_strobe_inst (
    .sys_clk_i      (sys_clk_i),
    .reset_n_i      (reset_n_i),
    .cycle_strobe_o (cycle_strobe_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bus_undriven: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    chip_select_n_i |=> !host_data_oe_o)
    else $error("bus driven while not selected");

  a_write_sets_full: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    write_done |=> input_full_flag_o
      && command_data_flag_o == $past(held_select))
    else $error("write did not set input full");

  a_flag_held_strobe: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (state == sphb_pkg::SPHB_WRITE && !write_n_i
      && !load_input_buffer_to_acc_i)
    |=> $stable(input_full_flag_o))
    else $error("input full moved during strobe");

  a_load_clears_in: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (load_input_buffer_to_acc_i && !write_done) |=> !input_full_flag_o)
    else $error("input full not cleared");

  a_store_sets_out: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    store_acc_to_output_buffer_i |=> output_full_flag_o
      && output_buffer == $past(acc_i))
    else $error("output full not set");

  a_read_clears_out: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (data_read_done && !store_acc_to_output_buffer_i) |=> !output_full_flag_o)
    else $error("data read did not clear output full");

  a_user_bits_load: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    load_user_status_bits_i |=> status_o[7:4] == $past(acc_i[7:4]))
    else $error("user status bits wrong");

  a_read_data_mux: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (sel_read && !data_command_select_i) |=> host_data_oe_o
      && host_data_o == $past(output_buffer))
    else $error("read data not output buffer");

  a_status_read_mux: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (sel_read && data_command_select_i) |=> host_data_oe_o
      && host_data_o == $past(status_o))
    else $error("read data not status");

endmodule

// ===== test/sphb_master_model.sv
`timescale 1ns/1ns
module sphb_master_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rd_data_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            sel_o,
  output logic      [7:0] wr_data_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 1'b0;
    wr_data_o = 8'h00;
  end
  // ----------------------------------------
  // One byte: strobe two cycles, then idle
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic cs, input logic sel,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_i);
    cs_n_o <= !cs;
    sel_o <= sel;
    wr_data_o <= d;
    wr_n_o <= !wr;
    rd_n_o <= wr;
    repeat (2) @(posedge sys_clk_i);
    q = rd_data_i;
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wr_data_o <= ~d;
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule

// ===== test/slave_peripheral_host_buffer_tb.sv
`timescale 1ns/1ns
module slave_peripheral_host_buffer_tb;
  localparam logic [7:0] OUT_FULL = 8'h01 << sphb_pkg::STS_OUT_FULL_BIT;
  localparam logic [7:0] IN_FULL  = 8'h01 << sphb_pkg::STS_IN_FULL_BIT;
  localparam logic [7:0] F0       = 8'h01 << sphb_pkg::STS_F0_BIT;
  localparam logic [7:0] CD       = 8'h01 << sphb_pkg::STS_CD_BIT;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       cs_n, rd_n, wr_n, sel, oe, in_full, out_full, cmd_flag, stb;
  logic       user_flag0_i = 1'b0;
  logic [2:0] loc = 3'h0;
  logic [7:0] acc_i = 8'h00;
  logic [7:0] wdata, q, rdata, ibuf, status;
  logic [9:0] pc;
  int         errors = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  sphb_master_model sphb_master_model_inst (.sys_clk_i(sys_clk_i),
    .rd_data_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .sel_o(sel), .wr_data_o(wdata));
  sphb_host_port sphb_host_port_inst (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .chip_select_n_i(cs_n), .read_n_i(rd_n),
    .write_n_i(wr_n), .data_command_select_i(sel), .host_data_i(wdata),
    .host_data_o(rdata), .host_data_oe_o(oe), .acc_i(acc_i),
    .load_input_buffer_to_acc_i(loc[0]),
    .store_acc_to_output_buffer_i(loc[1]),
    .load_user_status_bits_i(loc[2]), .user_flag0_i(user_flag0_i),
    .input_buffer_o(ibuf), .input_full_flag_o(in_full),
    .output_full_flag_o(out_full), .command_data_flag_o(cmd_flag),
    .status_o(status), .program_counter_o(pc), .cycle_strobe_o(stb));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      chk(8'h00, 8'h01, "timeout");
      end_of_test();
    end
  end
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    loc[i] <= 1'b1;
    @(posedge sys_clk_i);
    loc[i] <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic xfer_mid(input logic wr, cs, s, input logic [7:0] d,
                          input logic [7:0] exp, input string msg);
    fork
      sphb_master_model_inst.xfer(wr, cs, s, d, q);
      begin
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk({6'h00, oe, in_full}, exp, msg);
      end
    join
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    #1;
    chk(status, 8'h00, "status after reset");
    chk(ibuf, sphb_pkg::BUF_RESET, "input buffer after reset");
    chk(rdata, sphb_pkg::BUF_RESET, "read data after reset");
    chk({4'h0, in_full, out_full, cmd_flag, oe}, 8'h00, "flags");
    chk({7'h00, pc != 10'h000}, 8'h00, "counter reset");
  endtask
  task automatic t_write();
    xfer_mid(1'b1, 1'b1, 1'b0, 8'ha5, 8'h00, "flag while held");
    chk(ibuf, 8'ha5, "data byte");
    chk(status, IN_FULL, "write status");
    pulse(0);
    chk(status, 8'h00, "load clear");
    xfer_mid(1'b1, 1'b1, 1'b1, 8'h3c, 8'h00, "cmd held");
    chk(status, IN_FULL | CD, "command status");
    chk(ibuf, 8'h3c, "command byte");
  endtask
  task automatic t_cs();
    pulse(0);
    xfer_mid(1'b1, 1'b0, 1'b0, 8'hff, 8'h00, "write unselected");
    chk({ibuf[6:0], in_full}, {7'h3c, 1'b0}, "write ignored");
    xfer_mid(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, "read unselected");
  endtask
  task automatic t_read();
    @(posedge sys_clk_i);
    acc_i <= 8'h5a;
    pulse(1);
    chk(status, OUT_FULL | CD, "store status");
    xfer_mid(1'b0, 1'b1, 1'b1, 8'h00, 8'h02, "status drive");
    chk(q, OUT_FULL | CD, "status read");
    chk({7'h00, out_full}, 8'h01, "status read keeps full");
    xfer_mid(1'b0, 1'b1, 1'b0, 8'h00, 8'h02, "data drive");
    chk(q, 8'h5a, "data read");
    chk({6'h00, oe, out_full}, 8'h00, "after data read");
  endtask
  task automatic t_user();
    @(posedge sys_clk_i);
    acc_i        <= 8'hc3;
    user_flag0_i <= 1'b1;
    pulse(2);
    chk(status, 8'hc0 | CD | F0, "user bits");
  endtask
  task automatic t_cycle();
    int         n;
    logic [9:0] pc0;
    while (stb !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
    end
    pc0 = pc;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge sys_clk_i);
        #1;
        n++;
      end while (stb !== 1'b1);
      chk(8'(n), 8'(sphb_pkg::CYCLE_CLKS), "strobe spacing");
    end
    chk(8'(pc - pc0), 8'h02, "counter steps");
  endtask
  task automatic t_mid_reset();
    xfer_mid(1'b1, 1'b1, 1'b0, 8'h96, 8'h00, "early write");
    pulse(1);
    chk(status, 8'hc0 | F0 | IN_FULL | OUT_FULL, "before reset");
    @(posedge sys_clk_i);
    reset_n_i    <= 1'b0;
    user_flag0_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_write();
    t_cs();
    t_read();
    t_user();
    t_cycle();
    t_mid_reset();
    end_of_test();
  end
endmodule
